// file: design/sfpi_lane_io.sv
// pin multiplexer: lane directions and the guard and pause pin functions
`timescale 1ns/1ps
module sfpi_lane_io (
	sfpi_lane_if.pins lio
);
	import sfpi_pkg::*;

	wire       quad_drive = (lio.tx_w == W_QUAD) && lio.qe;
	wire       dual_drive = (lio.tx_w == W_DUAL);
	wire       drive      = lio.selected && lio.tx_on && !lio.pause;
	wire [3:0] lanes_used = quad_drive ? 4'hF : dual_drive ? 4'h3 : 4'h2;
	wire [3:0] quad_bits  = lio.tx_bits;
	wire [3:0] dual_bits  = {2'b00, lio.tx_bits[3:2]};
	wire [3:0] one_bit    = {2'b00, lio.tx_bits[3], 1'b0};

	// deselected or paused means every lane floats
	assign lio.pin_oe  = drive ? lanes_used : 4'h0;
	assign lio.pin_out = quad_drive ? quad_bits :
		dual_drive ? dual_bits : one_bit;
	// with quad enabled these pins are lanes, their control meaning is gone
	assign lio.hold_fn = !lio.qe;
	assign lio.hold_n  = lio.pin_in[3] | lio.qe;
	assign lio.wp_n    = lio.pin_in[2] | lio.qe;
endmodule : sfpi_lane_io

// file: design/sfpi_top.sv
// serial flash pin front end: link engine on the host clock, core on i_clock
`timescale 1ns/1ps

// What this block does
// - chip select high floats every data lane
// - instructions wait for first select falling edge
// - single lane input captured on rising edge
// - single lane output changes on falling edge
// - dual and quad: capture rising, drive falling
// - single and dual use lanes zero and one
// - quad instructions need quad enable set
// - quad enable turns guard and pause into lanes
// - guard pin low with lock refuses status writes
// - region guard from block, side, unit, complement
// - pause low while selected floats and ignores
// - pause release resumes exactly where stopped
// - 4096 pages of 256 bytes, program 1-256
// - erase sector, 32KB, 64KB block or chip
// - continuous read takes address without opcode
// - identity bytes and 64-bit unique number readable
// - three security registers with sticky locks
// - clock mode 0 or 3 both accepted
// - pause starts and ends on low clock
// - quad enable resets to zero
module sfpi_top #(
	parameter logic [7:0]  MFR_ID    = 8'h5A, // arbitrary
	parameter logic [15:0] DEVICE_ID = 16'hA5C3, // arbitrary
	parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // arbitrary
) (
	input  wire logic                    i_clock,
	input  wire logic                    i_reset,
	input  wire logic                    i_clock_en,
	input  wire logic                    i_link_sclk,
	input  wire logic                    i_cs_n,
	input  wire logic [3:0]              i_lane_in,
	output wire logic [3:0]              o_lane_out,
	output wire logic [3:0]              o_lane_oe,
	output logic      [7:0]              o_rx_byte,
	output logic                         o_rx_valid,
	output logic                         o_rx_first,
	output logic                         o_frame_end,
	input  wire logic [7:0]              i_tx_byte,
	input  wire logic                    i_tx_valid,
	output wire logic                    o_tx_ready,
	input  wire logic                    i_qe_load,
	input  wire logic                    i_qe_value,
	output wire logic                    o_quad_lane_enable,
	input  wire logic                    i_four_lane_enter,
	input  wire logic                    i_four_lane_exit,
	output wire logic                    o_four_lane_command_mode,
	input  wire logic                    i_execute_in_place,
	input  wire logic                    i_status_lock_select,
	output logic                         o_status_write_allow,
	input  wire logic [2:0]              i_region_guard_bits,
	input  wire logic                    i_top_bottom_select,
	input  wire logic                    i_small_unit_guard,
	input  wire logic                    i_complement_guard,
	input  wire logic [sfpi_pkg::ADDR_W-1:0] i_check_addr,
	output logic                         o_addr_guarded,
	output logic [sfpi_pkg::PAGE_IDX_W-1:0] o_page_index,
	input  wire sfpi_pkg::sfpi_erase_e   i_erase_kind,
	output logic [sfpi_pkg::ADDR_W-1:0]  o_erase_base,
	input  wire logic [3:0]              i_ident_index,
	output logic      [7:0]              o_ident_byte,
	input  wire logic [sfpi_pkg::SEC_REG_COUNT-1:0] i_sec_lock_init,
	input  wire logic [sfpi_pkg::SEC_REG_COUNT-1:0] i_sec_lock_set,
	output wire logic [sfpi_pkg::SEC_REG_COUNT-1:0] o_sec_write_allow
);
	import sfpi_pkg::*;

	sfpi_lane_if lio ();

	sfpi_lane_io u_lane_io (
		.lio (lio)
	);

	// link domain: host clock; all but the data byte and the config synchronizers cleared asynchronously by select high
	logic [2:0]  cnt_q;
	logic [7:0]  shift_q;
	logic [7:0]  rx_byte_q;
	logic        first_q;
	logic        rx_tog_q;
	sfpi_width_e rx_w_q;
	sfpi_width_e tx_w_q;
	logic        qe_s1, qe_s2;
	logic        four_s1, four_s2;
	logic        xip_s1, xip_s2;
	logic        req_s1, req_s2;
	logic        ack_q;
	logic        tx_on_q;
	logic [7:0]  tx_shift_q;
	logic        hold_q;

	// core domain
	logic        cs_s1, cs_s2, cs_s3;
	logic        wp_s1, wp_s2;
	logic        tog_s1, tog_s2, tog_s3, tog_s4;
	logic        ack_s1, ack_s2;
	logic        seen_high_q;
	logic        frame_ok_q;
	logic        first_rx_q;
	logic        req_q;
	logic [7:0]  tx_data_q;
	logic        qe_q;
	logic        four_q;
	logic        init_done_q;
	logic [SEC_REG_COUNT-1:0] sec_lock_q;

	// pause test reads the clock level: low clock acts now, high waits
	wire         pause_raw = !lio.hold_n && lio.hold_fn;
	wire         pause     = i_link_sclk ? hold_q : pause_raw;
	wire         xip_start = xip_s2 && qe_s2;
	wire sfpi_width_e start_w = (four_s2 || xip_start) ? W_QUAD : W_SINGLE;
	wire sfpi_width_e eff_w   = first_q ? start_w :
		(tx_on_q ? tx_w_q : rx_w_q);
	wire [2:0]   cnt_d     = cnt_q + sfpi_step(eff_w);
	wire         byte_done = (cnt_d == 3'h0);
	wire [7:0]   shift_d   = (eff_w == W_QUAD) ? {shift_q[3:0], i_lane_in[3:0]} :
		(eff_w == W_DUAL) ? {shift_q[5:0], i_lane_in[1:0]} :
		{shift_q[6:0], i_lane_in[0]};
	wire         opcode_ok = !four_s2 && !xip_start;

	assign lio.tx_bits  = tx_shift_q[7:4];
	assign lio.tx_on    = tx_on_q;
	assign lio.tx_w     = tx_w_q;
	assign lio.selected = !i_cs_n;
	assign lio.pause    = pause;
	assign lio.qe       = qe_s2;
	assign lio.pin_in   = i_lane_in;
	assign o_lane_out   = lio.pin_out;
	assign o_lane_oe    = lio.pin_oe;

	// capture side; a paused edge leaves all progress untouched
	// the clock was low just before a rising edge, so the pin level itself
	// is the pause state here; the muxed pause would race the clock
	always_ff @(posedge i_link_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			cnt_q    <= 3'h0;
			shift_q  <= 8'h00;
			first_q  <= 1'b1;
			rx_tog_q <= 1'b0;
			rx_w_q   <= W_SINGLE;
			tx_w_q   <= W_SINGLE;
		end else if (!pause_raw) begin
			cnt_q   <= cnt_d;
			shift_q <= shift_d;
			if (byte_done) begin
				rx_tog_q <= !rx_tog_q;
				first_q  <= 1'b0;
				if (first_q) begin
					rx_w_q <= opcode_ok ? sfpi_rx_width(shift_d, qe_s2) :
						start_w;
					tx_w_q <= opcode_ok ? sfpi_tx_width(shift_d, qe_s2) :
						start_w;
				end
			end
		end
	end

	// data only; the toggle tells the core when it is stable
	always_ff @(posedge i_link_sclk) begin
		if (!pause_raw && byte_done)
			rx_byte_q <= shift_d;
	end

	// pause state of the high phase is frozen at the rising edge, so a
	// pause pin change while the clock is high acts after the next fall
	always_ff @(posedge i_link_sclk or posedge i_cs_n) begin
		if (i_cs_n)
			hold_q <= 1'b0;
		else
			hold_q <= pause_raw;
	end

	// config levels from the core; they settle after two host clock edges
	always_ff @(posedge i_link_sclk) begin
		qe_s1   <= qe_q;
		qe_s2   <= qe_s1;
		four_s1 <= four_q;
		four_s2 <= four_s1;
		xip_s1  <= i_execute_in_place;
		xip_s2  <= xip_s1;
	end

	// drive side: output changes only on falling edges
	always_ff @(negedge i_link_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			req_s1     <= 1'b0;
			req_s2     <= 1'b0;
			ack_q      <= 1'b0;
			tx_on_q    <= 1'b0;
			tx_shift_q <= 8'h00;
		end else begin
			req_s1 <= req_q;
			req_s2 <= req_s1;
			if (!req_s2)
				ack_q <= 1'b0;
			if (!hold_q) begin
				if (cnt_q == 3'h0) begin
					tx_on_q <= req_s2 && !ack_q;
					if (req_s2 && !ack_q) begin
						tx_shift_q <= tx_data_q;
						ack_q      <= 1'b1;
					end
				end else begin
					tx_shift_q <= tx_shift_q << sfpi_step(tx_w_q);
				end
			end
		end
	end

	// core side of the crossings and the select sequencing
	wire rx_event     = (tog_s3 != tog_s4) && !cs_s2;
	wire cs_rise      = cs_s2 && !cs_s3;
	wire cs_fall      = !cs_s2 && cs_s3;
	wire frame_active = !cs_s2 && frame_ok_q;
	wire wp_asserted  = !wp_s2 && !qe_q;
	wire [IDENT_HEAD*8+UID_BITS-1:0] ident_all = {MFR_ID, DEVICE_ID, UNIQUE_ID};
	wire [IDENT_HEAD*8+UID_BITS-1:0] ident_sh  = ident_all << {i_ident_index, 3'h0};

	assign o_tx_ready               = frame_active && !req_q && !ack_s2;
	assign o_quad_lane_enable       = qe_q;
	assign o_four_lane_command_mode = four_q;
	assign o_sec_write_allow        = ~sec_lock_q;

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			// reset reads as selected: only a real high level arms a frame
			{cs_s1, cs_s2, cs_s3} <= 3'h0;
			{wp_s1, wp_s2}        <= 2'h3;
			{tog_s1, tog_s2, tog_s3, tog_s4} <= 4'h0;
			{ack_s1, ack_s2}      <= 2'h0;
		end else if (i_clock_en) begin
			cs_s1  <= i_cs_n;
			cs_s2  <= cs_s1;
			cs_s3  <= cs_s2;
			wp_s1  <= lio.wp_n;
			wp_s2  <= wp_s1;
			tog_s1 <= rx_tog_q;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			tog_s4 <= tog_s3;
			ack_s1 <= ack_q;
			ack_s2 <= ack_s1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			seen_high_q <= 1'b0;
			frame_ok_q  <= 1'b0;
			first_rx_q  <= 1'b0;
			o_rx_valid  <= 1'b0;
			o_rx_first  <= 1'b0;
			o_frame_end <= 1'b0;
			o_rx_byte   <= 8'h00;
		end else if (i_clock_en) begin
			o_rx_valid  <= rx_event && frame_ok_q;
			o_rx_first  <= rx_event && frame_ok_q && first_rx_q;
			o_frame_end <= cs_rise && frame_ok_q;
			if (cs_s2)
				seen_high_q <= 1'b1;
			if (cs_fall) begin
				frame_ok_q <= seen_high_q;
				first_rx_q <= 1'b1;
			end else if (cs_rise) begin
				frame_ok_q <= 1'b0;
			end
			if (rx_event) begin
				o_rx_byte  <= rx_byte_q;
				first_rx_q <= 1'b0;
			end
		end
	end

	// four phase request toward the drive side; a frame end drops it
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			req_q     <= 1'b0;
			tx_data_q <= 8'h00;
		end else if (i_clock_en) begin
			if (cs_rise || ack_s2)
				req_q <= 1'b0;
			else if (i_tx_valid && o_tx_ready) begin
				req_q     <= 1'b1;
				tx_data_q <= i_tx_byte;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			qe_q        <= QE_RESET;
			four_q      <= FOUR_LANE_RESET;
			init_done_q <= 1'b0;
			sec_lock_q  <= SEC_LOCK_RESET;
		end else if (i_clock_en) begin
			if (i_qe_load)
				qe_q <= i_qe_value;
			if (!qe_q || i_four_lane_exit)
				four_q <= 1'b0;
			else if (i_four_lane_enter)
				four_q <= 1'b1;
			init_done_q <= 1'b1;
			if (!init_done_q)
				sec_lock_q <= i_sec_lock_init | i_sec_lock_set;
			else
				sec_lock_q <= sec_lock_q | i_sec_lock_set;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_status_write_allow <= 1'b1;
			o_addr_guarded       <= 1'b0;
			o_page_index         <= '0;
			o_erase_base         <= '0;
			o_ident_byte         <= 8'h00;
		end else if (i_clock_en) begin
			o_status_write_allow <= !(i_status_lock_select && wp_asserted);
			o_addr_guarded <= sfpi_region_guarded(i_check_addr,
				i_region_guard_bits, i_top_bottom_select,
				i_small_unit_guard, i_complement_guard);
			o_page_index <= i_check_addr[ADDR_W-1:PAGE_BITS];
			o_erase_base <= sfpi_erase_base(i_check_addr, i_erase_kind);
			o_ident_byte <= ident_sh[IDENT_HEAD*8+UID_BITS-1 -: 8];
		end
	end

	deselect_float_a: assert property (
		@(posedge i_clock) i_cs_n |-> (o_lane_oe == 4'h0))
		else $error("lanes driven while deselected");

	arm_first_a: assert property (
		@(posedge i_clock) disable iff (i_reset)
		o_rx_valid |-> seen_high_q && $past(frame_ok_q))
		else $error("byte delivered before select sequence");

	pause_float_a: assert property (
		@(posedge i_clock) (pause && !i_cs_n) |-> (o_lane_oe == 4'h0))
		else $error("lanes driven during pause");

	pause_keep_a: assert property (
		@(posedge i_link_sclk) disable iff (i_cs_n)
		pause |=> (shift_q == $past(shift_q)) && (cnt_q == $past(cnt_q)))
		else $error("progress changed during pause");

	quad_gate_a: assert property (
		@(posedge i_link_sclk) disable iff (i_cs_n)
		(!qe_s2 && !first_q) |-> (rx_w_q != W_QUAD) && (tx_w_q != W_QUAD))
		else $error("quad lanes without quad enable");

	status_guard_a: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(i_clock_en && i_status_lock_select && wp_asserted)
		|=> !o_status_write_allow)
		else $error("status write allowed under guard");

	quad_reset_a: assert property (
		@(posedge i_clock) $past(i_reset) |-> !qe_q && !four_q)
		else $error("quad enable not clear after reset");

	sector_base_a: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(i_clock_en && i_erase_kind == ERASE_SECTOR)
		|=> (o_erase_base[SECTOR_SHIFT-1:0] == '0))
		else $error("sector base not aligned");

	lock_sticky_a: assert property (
		@(posedge i_clock) disable iff (i_reset)
		init_done_q |=> ((sec_lock_q & $past(sec_lock_q)) == $past(sec_lock_q)))
		else $error("security lock cleared");

	frame_drop_a: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(i_clock_en && cs_rise) |=> !req_q && !o_tx_ready)
		else $error("request kept past frame end");
endmodule : sfpi_top

// file: inc/sfpi_lane_if.sv
// lane signals between the serial engine and the pin multiplexer
`timescale 1ns/1ps
interface sfpi_lane_if;
	import sfpi_pkg::*;
	logic [3:0]  tx_bits;
	logic        tx_on;
	sfpi_width_e tx_w;
	logic        selected;
	logic        pause;
	logic        qe;
	logic [3:0]  pin_in;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe;
	logic        hold_n;
	logic        hold_fn;
	logic        wp_n;

	modport engine (output tx_bits, tx_on, tx_w, selected, pause, qe, pin_in,
		input pin_out, pin_oe, hold_n, hold_fn, wp_n);
	modport pins (input tx_bits, tx_on, tx_w, selected, pause, qe, pin_in,
		output pin_out, pin_oe, hold_n, hold_fn, wp_n);
endinterface : sfpi_lane_if

// file: inc/sfpi_pkg.sv
// shared constants, types and helper functions of the serial flash pin block
package sfpi_pkg;
	localparam int ADDR_W        = 20;
	localparam int PAGE_BITS     = 8;
	localparam int PAGE_COUNT    = 4096;
	localparam int PAGE_BYTES    = 256;
	localparam int SECTOR_PAGES  = 16;
	localparam int BLOCK32_PAGES = 128;
	localparam int BLOCK64_PAGES = 256;
	localparam int SECTOR_SHIFT  = PAGE_BITS + $clog2(SECTOR_PAGES);
	localparam int BLOCK32_SHIFT = PAGE_BITS + $clog2(BLOCK32_PAGES);
	localparam int BLOCK64_SHIFT = PAGE_BITS + $clog2(BLOCK64_PAGES);
	localparam int PAGE_IDX_W    = $clog2(PAGE_COUNT);
	localparam int SEC_REG_COUNT = 3;
	localparam int SEC_REG_BYTES = 256;
	localparam int UID_BITS      = 64;
	localparam int IDENT_HEAD    = 3;

	localparam logic                     QE_RESET        = 1'b0;
	localparam logic                     FOUR_LANE_RESET = 1'b0;
	localparam logic [SEC_REG_COUNT-1:0] SEC_LOCK_RESET  = 3'h0;

	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_IO  = 8'hBB;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_QUAD_IO  = 8'hEB;

	typedef enum logic [1:0] {
		W_SINGLE = 2'b00,
		W_DUAL   = 2'b01,
		W_QUAD   = 2'b10
	} sfpi_width_e;

	typedef enum logic [1:0] {
		ERASE_SECTOR  = 2'b00,
		ERASE_BLOCK32 = 2'b01,
		ERASE_BLOCK64 = 2'b10,
		ERASE_CHIP    = 2'b11
	} sfpi_erase_e;

	function automatic logic [2:0] sfpi_step(input sfpi_width_e w);
		return (w == W_QUAD) ? 3'h4 : (w == W_DUAL) ? 3'h2 : 3'h1;
	endfunction : sfpi_step

	// quad classes fall back to one lane while the quad enable is clear
	function automatic sfpi_width_e sfpi_rx_width(input logic [7:0] op,
		input logic qe);
		if (op == OP_QUAD_IO && qe)
			return W_QUAD;
		if (op == OP_DUAL_IO)
			return W_DUAL;
		return W_SINGLE;
	endfunction : sfpi_rx_width

	function automatic sfpi_width_e sfpi_tx_width(input logic [7:0] op,
		input logic qe);
		if ((op == OP_QUAD_IO || op == OP_QUAD_OUT) && qe)
			return W_QUAD;
		if (op == OP_DUAL_IO || op == OP_DUAL_OUT)
			return W_DUAL;
		return W_SINGLE;
	endfunction : sfpi_tx_width

	function automatic logic [ADDR_W-1:0] sfpi_erase_base(
		input logic [ADDR_W-1:0] addr, input sfpi_erase_e kind);
		logic [ADDR_W-1:0] mask;
		mask = '0;
		unique case (kind)
			ERASE_SECTOR:  mask = ~((ADDR_W'(1) << SECTOR_SHIFT) - ADDR_W'(1));
			ERASE_BLOCK32: mask = ~((ADDR_W'(1) << BLOCK32_SHIFT) - ADDR_W'(1));
			ERASE_BLOCK64: mask = ~((ADDR_W'(1) << BLOCK64_SHIFT) - ADDR_W'(1));
			ERASE_CHIP:    mask = '0;
		endcase
		return addr & mask;
	endfunction : sfpi_erase_base

	// tb high guards the bottom of the array, cmp inverts the region
	function automatic logic sfpi_region_guarded(input logic [ADDR_W-1:0] addr,
		input logic [2:0] bp, input logic tb, input logic sec, input logic cmp);
		logic [4:0]        sh;
		logic [ADDR_W-1:0] hi;
		logic              hit;
		if (sec)
			sh = (bp >= 3'h4) ? 5'(BLOCK32_SHIFT) :
				5'(SECTOR_SHIFT - 1) + {2'b00, bp};
		else
			sh = 5'(BLOCK64_SHIFT - 1) + {2'b00, bp};
		hi = addr >> sh;
		if (bp == 3'h0)
			hit = 1'b0;
		else if (sh >= 5'(ADDR_W))
			hit = 1'b1;
		else if (tb)
			hit = (hi == '0);
		else
			hit = (hi == ({ADDR_W{1'b1}} >> sh));
		return hit ^ cmp;
	endfunction : sfpi_region_guarded
endpackage : sfpi_pkg

// file: tb/sfpi_host_model.sv
// host side model: drives the serial link and samples the lanes
`timescale 1ns/1ps
module sfpi_host_model (
	input  wire logic [3:0] i_lane,
	input  wire logic [3:0] i_oe,
	output logic            o_sclk,
	output logic            o_cs_n,
	output logic [3:0]      o_lane
);
	logic cpol;
	initial begin
		cpol = 1'b0;
		o_sclk = 1'b0;
		o_cs_n = 1'b0;
		o_lane = 4'hd;
		// pulse inside the core reset clears the link side unseen
		#2 o_cs_n = 1'b1;
		#20 o_cs_n = 1'b0;
	end
	// a released line must not keep showing the last bit it carried
	always @(negedge o_sclk)
		o_lane[1] <= ~o_lane[1];
	task automatic sel();
		o_sclk = cpol;
		#100 o_cs_n = 1'b0;
		#80;
	endtask : sel
	task automatic desel();
		#80 o_cs_n = 1'b1;
		#200;
	endtask : desel
	task automatic xfer(input logic [7:0] d, input int n, input int w,
		output logic [7:0] got, output logic [3:0] ov);
		logic [7:0] s;
		s = d;
		got = 8'h00;
		ov = 4'h0;
		repeat (n) begin
			o_sclk = 1'b0;
			o_lane[0] = s[7];
			s = s << 1;
			#80 o_sclk = 1'b1;
			if (w == 4)
				got = {got[3:0], i_lane};
			else if (w == 2)
				got = {got[5:0], i_lane[1:0]};
			else
				got = {got[6:0], i_lane[1]};
			ov = ov | i_oe;
			#80;
		end
		if (!cpol)
			o_sclk = 1'b0;
	endtask : xfer
	// clock pulses while paused must be ignored; chip select stays low
	task automatic pause(output logic [3:0] ov);
		logic [7:0] g;
		o_lane[3] = 1'b0;
		#80;
		xfer(8'hff, 3, 1, g, ov);
		o_lane[3] = 1'b1;
		#80;
	endtask : pause
endmodule : sfpi_host_model

// file: tb/sfpi_top_test.sv
// self-checking bench of the serial flash pin front end
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
	num_errors++; $display("[FAIL] %0t value mismatch", $time); end end
module sfpi_top_test;
	import sfpi_pkg::*;
	localparam logic [7:0]  MFR = 8'h3c; // arbitrary
	localparam logic [15:0] DEV = 16'h9e21; // arbitrary
	localparam logic [63:0] UID = 64'h1357_9bdf_2468_ace0; // arbitrary
	int          num_errors = 0;
	int          num_checks = 0;
	logic        i_clock = 1'b0;
	logic        i_reset = 1'b1;
	logic        sclk, cs_n, rx_valid, rx_first, tx_ready, qe, swa, grd;
	logic [3:0]  h_lane, lane_out, lane_oe, idx = 4'h0;
	logic [7:0]  rx_byte, ident, tx_byte = 8'h00;
	logic        tx_valid = 1'b0, qe_load = 1'b0, lock_sel = 1'b0;
	logic [2:0]  bp = 3'h0, lset = 3'h0, wal;
	logic        tb = 1'b0, sec = 1'b0, cmp = 1'b0, mute = 1'b0;
	logic        clk_en = 1'b1, qev = 1'b0, fen = 1'b0, fex = 1'b0;
	logic        fend, fourm;
	int          n_end = 0;
	logic [19:0] addr = 20'h0_0000, ebase;
	logic [11:0] page;
	sfpi_erase_e ekind = ERASE_SECTOR;
	logic [8:0]  exp_q[$];
	wire  [3:0]  lane_in = (lane_oe & lane_out) | (~lane_oe & h_lane);
	always #4 i_clock = ~i_clock;

	sfpi_host_model HOST (.i_lane(lane_in), .i_oe(lane_oe), .o_sclk(sclk),
		.o_cs_n(cs_n), .o_lane(h_lane));
	sfpi_top #(.MFR_ID(MFR), .DEVICE_ID(DEV), .UNIQUE_ID(UID)) DUT (
		.i_clock(i_clock), .i_reset(i_reset), .i_clock_en(clk_en),
		.i_link_sclk(sclk), .i_cs_n(cs_n), .i_lane_in(lane_in),
		.o_lane_out(lane_out), .o_lane_oe(lane_oe), .o_rx_byte(rx_byte),
		.o_rx_valid(rx_valid), .o_rx_first(rx_first), .o_frame_end(fend),
		.i_tx_byte(tx_byte), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
		.i_qe_load(qe_load), .i_qe_value(qev), .o_quad_lane_enable(qe),
		.i_four_lane_enter(fen), .i_four_lane_exit(fex),
		.o_four_lane_command_mode(fourm), .i_execute_in_place(1'b0),
		.i_status_lock_select(lock_sel), .o_status_write_allow(swa),
		.i_region_guard_bits(bp), .i_top_bottom_select(tb),
		.i_small_unit_guard(sec), .i_complement_guard(cmp),
		.i_check_addr(addr), .o_addr_guarded(grd), .o_page_index(page),
		.i_erase_kind(ekind), .o_erase_base(ebase), .i_ident_index(idx),
		.o_ident_byte(ident), .i_sec_lock_init(3'h1),
		.i_sec_lock_set(lset), .o_sec_write_allow(wal));

	// received bytes are checked against the notes left by the driver;
	// sampled mid-cycle so the registered pulse has settled
	always @(negedge i_clock) begin
		if (rx_valid === 1'b1 && !mute) begin
			if (exp_q.size() == 0) begin
				`CHK(1'b1, 1'b0)
			end else begin
				`CHK({rx_first, rx_byte}, exp_q.pop_front())
			end
		end
	end

	always @(negedge i_clock)
		if (fend === 1'b1)
			n_end++;

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : cyc
	// tx byte offered after select; expect it on the lanes of mask m
	task automatic rd(input logic [7:0] op, input int w, input logic [3:0] m);
		logic [7:0] g, g0, r;
		logic [3:0] vx, v0, v1;
		r = 8'($urandom);
		mute = 1'b1;
		HOST.sel();
		@(posedge i_clock);
		tx_byte <= r;
		tx_valid <= 1'b1;
		fork
			begin
				HOST.xfer(op, 8, 1, g, vx);
				HOST.xfer(8'h00, 8 / w, w, g0, v0);
				HOST.xfer(8'h00, 8 / w, w, g, v1);
				HOST.desel();
			end
			begin
				repeat (4000) begin
					@(posedge i_clock);
					if (tx_ready === 1'b1)
						break;
				end
				tx_valid <= 1'b0;
			end
		join
		`CHK(vx, 4'h0)
		`CHK(g0, r)
		`CHK(v0, m)
		`CHK(v1, 4'h0)
		`CHK(lane_oe, 4'h0)
		mute = 1'b0;
	endtask : rd

	initial begin
		#400000;
		num_errors++;
		finish_test();
	end

	initial begin
		logic [7:0]  g;
		logic [3:0]  v;
		logic [19:0] a, eb;
		logic [87:0] id;
		int          k, sh;
		a = 20'($urandom(79506));
		id = {MFR, DEV, UID};
		cyc(16);
		@(posedge i_clock) i_reset <= 1'b0;
		cyc(3);
		`CHK(qe, 1'b0)
		`CHK(wal, 3'h6)
		@(posedge i_clock) fen <= 1'b1;
		@(posedge i_clock) fen <= 1'b0;
		cyc(2);
		`CHK(fourm, 1'b0)
		HOST.xfer(8'ha5, 8, 1, g, v); // no select edge seen yet
		cyc(20);
		HOST.desel();
		HOST.sel();
		HOST.xfer(8'hff, 5, 1, g, v);
		HOST.desel();
		`CHK(lane_oe, 4'h0)
		HOST.sel();
		exp_q.push_back(9'h13c);
		HOST.xfer(8'h3c, 8, 1, g, v);
		exp_q.push_back(9'h0c3);
		HOST.xfer(8'hc3, 4, 1, g, v);
		HOST.pause(v);
		`CHK(v, 4'h0)
		HOST.xfer(8'h30, 4, 1, g, v);
		HOST.desel();
		HOST.cpol = 1'b1;
		HOST.sel();
		exp_q.push_back(9'h15a);
		HOST.xfer(8'h5a, 8, 1, g, v);
		HOST.desel();
		HOST.cpol = 1'b0;
		rd(8'h03, 1, 4'h2);
		rd(OP_QUAD_OUT, 1, 4'h2);
		HOST.o_lane[2] = 1'b0;
		@(posedge i_clock) lock_sel <= 1'b1;
		cyc(4);
		`CHK(swa, 1'b0)
		@(posedge i_clock) {qe_load, qev} <= 2'b11;
		@(posedge i_clock) qe_load <= 1'b0;
		cyc(4);
		`CHK(qe, 1'b1)
		`CHK(swa, 1'b1)
		HOST.o_lane[2] = 1'b1;
		rd(OP_DUAL_OUT, 2, 4'h3);
		rd(OP_QUAD_OUT, 4, 4'hf);
		for (k = 0; k < 10; k++) begin
			a = 20'($urandom);
			sh = (k % 4 == 0) ? SECTOR_SHIFT :
				(k % 4 == 1) ? BLOCK32_SHIFT : BLOCK64_SHIFT;
			eb = (k % 4 == 3) ? 20'h0_0000 : (a >> sh) << sh;
			@(posedge i_clock) addr <= a;
			ekind <= sfpi_erase_e'(k % 4);
			cmp <= k[0];
			bp <= (k > 7) ? 3'h5 : 3'h0;
			cyc(2);
			`CHK(page, a[19:8])
			`CHK(ebase, eb)
			`CHK(grd, (k > 7) ? ~k[0] : k[0])
		end
		for (k = 0; k < 2; k++) begin
			@(posedge i_clock) addr <= k[0] ? 20'h0_1000 : 20'h0_0fff;
			{bp, sec, tb, cmp} <= 6'h0e;
			cyc(2);
			`CHK(grd, ~k[0])
		end
		for (k = 0; k < 11; k++) begin
			@(posedge i_clock) idx <= 4'(k);
			cyc(2);
			`CHK(ident, id[87 - 8 * k -: 8])
		end
		@(posedge i_clock) fen <= 1'b1;
		@(posedge i_clock) fen <= 1'b0;
		cyc(2);
		`CHK(fourm, 1'b1)
		@(posedge i_clock) fex <= 1'b1;
		@(posedge i_clock) fex <= 1'b0;
		cyc(2);
		`CHK(fourm, 1'b0)
		// enter and clearing quad enable together: the mode must not stay
		@(posedge i_clock) {fen, qe_load, qev} <= 3'b110;
		@(posedge i_clock) {fen, qe_load} <= 2'b00;
		cyc(2);
		`CHK({qe, fourm}, 2'b00)
		// a lock pulse while the clock enable is low must be lost
		@(posedge i_clock) clk_en <= 1'b0;
		lset <= 3'h2;
		@(posedge i_clock) lset <= 3'h0;
		cyc(2);
		`CHK(wal, 3'h6)
		@(posedge i_clock) clk_en <= 1'b1;
		@(posedge i_clock) lset <= 3'h2;
		@(posedge i_clock) lset <= 3'h0;
		cyc(6);
		`CHK(wal, 3'h4)
		`CHK(exp_q.size(), 0)
		`CHK(n_end, 7)
		finish_test();
	end
endmodule : sfpi_top_test
